// ==== hdl/an_adv_regs.sv ====
// Auto-negotiation advertisement registers for two PHYs, reached over APB
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module an_adv_regs #(
    parameter int unsigned NPHY = an_adv_pkg::NUM_PHY
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Per-PHY configuration straps, steady around reset release
    input wire an_adv_pkg::strap_set_t [NPHY-1:0] i_straps,
    // Advertised words toward the negotiation engines
    output logic [NPHY-1:0][15:0] o_adv_word
);

    // =====================================================================
    // Reset defaults derived from one PHY's straps
    // =====================================================================
    // Symmetric pause: offered by default only under automatic flow control on copper
    function automatic logic sym_pause_default(input an_adv_pkg::strap_set_t s);
        logic r;
        r = 1'b0;
        if (!s.fiber_mode && !s.manual_pause_select_latch)
        begin
            r = 1'b1;
        end
        // Manual strap or fiber leaves it clear
        return r;
    endfunction : sym_pause_default

    // Asymmetric pause: follows the full duplex pause strap in automatic mode
    function automatic logic asym_pause_default(input an_adv_pkg::strap_set_t s);
        logic r;
        r = 1'b0;
        if (!s.fiber_mode && !s.manual_pause_select_latch)
        begin
            r = s.full_duplex_pause_latch;
        end
        // Manual strap or fiber leaves it clear
        return r;
    endfunction : asym_pause_default

    // 10BASE-T full duplex: negotiation on, or forced 10 Mb/s at full duplex
    function automatic logic ten_fd_default(input an_adv_pkg::strap_set_t s);
        logic r;
        r = 1'b0;
        if (!s.fiber_mode)
        begin
            r = s.autoneg | (~s.speed & s.duplex);
        end
        // A fiber port never offers 10BASE-T
        return r;
    endfunction : ten_fd_default

    // 10BASE-T half duplex: negotiation on, or forced 10 Mb/s
    function automatic logic ten_hd_default(input an_adv_pkg::strap_set_t s);
        logic r;
        r = 1'b0;
        if (!s.fiber_mode)
        begin
            r = s.autoneg | ~s.speed;
        end
        // A fiber port never offers 10BASE-T
        return r;
    endfunction : ten_hd_default

    // Whole reset word: fixed fields first, then the strap-derived bits
    function automatic logic [15:0] strap_default(input an_adv_pkg::strap_set_t s);
        logic [15:0] v;
        v = an_adv_pkg::FIXED_RESET;
        v[an_adv_pkg::BIT_SYM_PAUSE] = sym_pause_default(s);
        v[an_adv_pkg::BIT_ASYM_PAUSE] = asym_pause_default(s);
        v[an_adv_pkg::BIT_10T_FD] = ten_fd_default(s);
        v[an_adv_pkg::BIT_10T_HD] = ten_hd_default(s);
        return v;
    endfunction : strap_default

    // =====================================================================
    // Address decode
    // =====================================================================
    // Address decode, shared by read and write paths
    function automatic logic [NPHY:0] decode(input logic [11:0] a);
        logic [NPHY:0] hit;
        hit = '0;
        for (int i = 0; i < NPHY; i++)
        begin
            if (a == 12'(an_adv_pkg::ADV_ADDR + i * an_adv_pkg::PHY_STRIDE))
            begin
                hit[i] = 1'b1;
            end
        end
        if (a == an_adv_pkg::STRAP_ADDR)
        begin
            hit[NPHY] = 1'b1;
        end
        return hit;
    endfunction : decode

    // =====================================================================
    // Strap capture: one clocked pass after reset release
    // =====================================================================
    logic load_pending_ff;
    logic nxt_load_pending;
    logic [NPHY-1:0][15:0] adv_ff;
    logic [NPHY-1:0][15:0] nxt_adv;
    logic [NPHY:0] hit;
    logic wr_en;
    logic [15:0] wmask;

    // Straps cannot be loaded under async reset, so load on first edge after it
    always_comb
    begin
        nxt_load_pending = 1'b0;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            load_pending_ff <= 1'b1;
        end
        else
        begin
            load_pending_ff <= nxt_load_pending;
        end
    end

    // =====================================================================
    // Register write path
    // =====================================================================
    assign hit = decode(i_paddr);
    assign wr_en = i_psel & i_penable & i_pwrite;
    // Write mask from the byte strobes
    assign wmask = lane_mask(i_pstrb);

    // Byte strobes gate each lane; reserved bits never take a write
    function automatic logic [15:0] lane_mask(input logic [3:0] strb);
        logic [15:0] m;
        m = 16'h0000;
        for (int b = 0; b < 2; b++)
        begin
            if (strb[b])
            begin
                m[b*8 +: 8] = 8'hFF;
            end
        end
        // Lanes 2 and 3 have no register bits behind them
        return m & an_adv_pkg::WRITE_MASK;
    endfunction : lane_mask

    // =====================================================================
    // Per-PHY register copies
    // =====================================================================
    // One word per PHY, so straps of one port never leak into the other
    generate
        for (genvar g = 0; g < NPHY; g++)
        begin : g_phy
            // Each PHY loads from its own strap set
            always_comb
            begin
                nxt_adv[g] = adv_ff[g];
                if (load_pending_ff)
                begin
                    nxt_adv[g] = strap_default(i_straps[g]);
                end
                else if (wr_en && hit[g])
                begin
                    // Extended next page is stored as written; software keeps it 0
                    nxt_adv[g] = (adv_ff[g] & ~wmask) | (i_pwdata[15:0] & wmask);
                end
            end

            always_ff @(posedge i_clk_sys or posedge i_rst)
            begin
                if (i_rst)
                begin
                    adv_ff[g] <= an_adv_pkg::FIXED_RESET;
                end
                else
                begin
                    adv_ff[g] <= nxt_adv[g];
                end
            end

            assign o_adv_word[g] = adv_ff[g];
        end
    endgenerate

    // =====================================================================
    // Read path: zero-wait APB, registered read data
    // =====================================================================
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic slverr_ff;
    logic nxt_slverr;

    // Setup cycle prepares data so the access phase completes at once
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (i_psel && !i_penable)
        begin
            nxt_rdata = 32'h0000_0000;
            for (int i = 0; i < NPHY; i++)
            begin
                if (hit[i])
                begin
                    nxt_rdata = {16'h0000, adv_ff[i]};
                end
            end
            if (hit[NPHY])
            begin
                nxt_rdata = strap_view(i_straps);
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Strap view: byte i shows PHY i strap levels live, as sampled in the setup cycle
    function automatic logic [31:0] strap_view(input an_adv_pkg::strap_set_t [NPHY-1:0] s);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int i = 0; i < NPHY; i++)
        begin
            w[i*8 +: 6] = s[i];
        end
        return w;
    endfunction : strap_view

    // =====================================================================
    // Error response
    // =====================================================================
    // Judged in the setup cycle, held through the access phase
    always_comb
    begin
        nxt_slverr = 1'b0;
        if (i_psel && !i_penable)
        begin
            // Unmapped, or a write to the read-only strap view
            nxt_slverr = ~|hit | (hit[NPHY] & i_pwrite);
        end
        else if (i_psel && i_penable)
        begin
            nxt_slverr = slverr_ff;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            slverr_ff <= 1'b0;
        end
        else
        begin
            slverr_ff <= nxt_slverr;
        end
    end

    // =====================================================================
    // Bus outputs
    // =====================================================================
    // Zero wait states: ready as soon as the access phase is seen
    assign o_pready = i_psel & i_penable;
    assign o_prdata = rdata_ff;
    assign o_pslverr = i_psel & i_penable & slverr_ff;

endmodule : an_adv_regs

// ==== inc/an_adv_pkg.sv ====
// Package: offsets, field positions and reset values of the advertisement register bank
package an_adv_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam int unsigned NUM_PHY = 2;
    // Register index 4 per PHY; byte address = 4 * index, PHY stride 0x40
    localparam logic [7:0] ADV_INDEX = 8'h04;
    localparam logic [11:0] ADV_ADDR = 12'h010;
    localparam logic [11:0] PHY_STRIDE = 12'h040;
    localparam logic [11:0] STRAP_ADDR = 12'h080;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int unsigned BIT_NEXT_PAGE = 15;
    localparam int unsigned BIT_RSVD_HI = 14;
    localparam int unsigned BIT_REMOTE_FAULT = 13;
    localparam int unsigned BIT_EXT_NEXT_PAGE = 12;
    localparam int unsigned BIT_ASYM_PAUSE = 11;
    localparam int unsigned BIT_SYM_PAUSE = 10;
    localparam int unsigned BIT_RSVD_LO = 9;
    localparam int unsigned BIT_100X_FD = 8;
    localparam int unsigned BIT_100X_HD = 7;
    localparam int unsigned BIT_10T_FD = 6;
    localparam int unsigned BIT_10T_HD = 5;

    // =====================================================================
    // Reset values and masks
    // =====================================================================
    localparam logic [4:0] SELECTOR_RESET = 5'h01;
    // Writable bits: all but 14 and 9
    localparam logic [15:0] WRITE_MASK = 16'hBDFF;
    localparam logic [15:0] FIXED_RESET = 16'h0181;

    // Per-PHY strap set
    typedef struct packed {
        logic manual_pause_select_latch;
        logic full_duplex_pause_latch;
        logic autoneg;
        logic speed;
        logic duplex;
        logic fiber_mode;
    } strap_set_t;

    // APB request carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

endpackage : an_adv_pkg

// ==== dv/an_adv_checker.sv ====
// Checker for the advertisement register bank ports
`timescale 1ns/1ps
module an_adv_checker #(
    parameter int unsigned NPHY = 2
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    // Advertised words
    input wire logic [NPHY-1:0][15:0] o_adv_word
);
    // =====================================================================
    // Helpers
    // =====================================================================
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    wire acc = i_psel && i_penable;
    wire wr = acc && i_pwrite && i_pstrb[1:0] == 2'b11;
    logic [15:0] wlo_ff;
    // Last write data, so the word can be tied to it one edge later
    always_ff @(posedge i_clk_sys) wlo_ff <= i_pwdata[15:0] & an_adv_pkg::WRITE_MASK;
    // =====================================================================
    // Properties
    // =====================================================================
    property p_ready; acc |-> o_pready; endproperty
    property p_rsvd; (o_adv_word[0] & 16'h4200) == 16'h0000; endproperty
    property p_wr0; wr && i_paddr == 12'h010 |=> o_adv_word[0] == wlo_ff; endproperty
    property p_wr1; wr && i_paddr == 12'h050 |=> o_adv_word[NPHY-1] == wlo_ff; endproperty
    property p_rd0;
        acc && !i_pwrite && i_paddr == 12'h010 |-> o_prdata == {16'h0000, o_adv_word[0]};
    endproperty
    property p_hold; !(acc && i_pwrite) && !$past(i_rst) |=> $stable(o_adv_word); endproperty
    property p_err; acc && !i_pwrite && i_paddr == 12'h0FC |-> o_pslverr && o_prdata == 32'h0;
    endproperty
    property p_ok; acc && i_paddr == 12'h010 |-> !o_pslverr; endproperty
    property p_strap_ro; acc && i_pwrite && i_paddr == 12'h080 |-> o_pslverr; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access phase");
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    a_wr0: assert property (p_wr0) else $error("phy0 write lost");
    a_wr1: assert property (p_wr1) else $error("phy1 write lost");
    a_rd0: assert property (p_rd0) else $error("read data differs");
    a_hold: assert property (p_hold) else $error("word changed without write");
    a_err: assert property (p_err) else $error("unmapped read not refused");
    a_ok: assert property (p_ok) else $error("error on mapped address");
    a_strap_ro: assert property (p_strap_ro) else $error("strap write accepted");
    c_wr: cover property (wr);
    c_rd: cover property (acc && !i_pwrite);
    c_err: cover property (o_pslverr);
endmodule : an_adv_checker
bind an_adv_regs an_adv_checker #(.NPHY(NPHY)) u_chk (.i_clk_sys, .i_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_prdata, .o_pslverr, .o_adv_word);

// ==== dv/lp_model.sv ====
// Link partner model that takes in the advertised base page
`timescale 1ns/1ps
module lp_model (
    // Clock
    input wire logic i_clk_sys,
    // Advertised word from the local PHY
    input wire logic [15:0] i_page,
    // Last page received
    output logic [15:0] o_seen
);
    // Samples every cycle; no acknowledge handshake is modelled
    always @(posedge i_clk_sys) o_seen <= i_page;
endmodule : lp_model

// ==== dv/an_adv_regs_tb.sv ====
// Self-checking bench for the advertisement register bank
`timescale 1ns/1ps
module an_adv_regs_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    an_adv_pkg::apb_req_t req = '0;
    an_adv_pkg::strap_set_t [1:0] straps = '0;
    logic rdy, err, ev;
    logic [31:0] prdata, rd;
    logic [1:0][15:0] adv;
    // Two partner models each drive one half of this
    wire logic [1:0][15:0] seen;
    logic [3:0] strb = 4'hF;
    logic [11:0] a;
    logic [15:0] seed = 16'hF094;
    int n_errors = 0, samples_checked = 0, cycles = 0;
    int model[2];
    an_adv_regs #(.NPHY(2)) DUT (.i_clk_sys(clk), .i_rst(rst), .i_psel(req.psel),
        .i_penable(req.penable), .i_pwrite(req.pwrite), .i_paddr(req.paddr),
        .i_pwdata(req.pwdata), .i_pstrb(req.pstrb), .o_pready(rdy), .o_prdata(prdata),
        .o_pslverr(err), .i_straps(straps), .o_adv_word(adv));
    lp_model lp0 (.i_clk_sys(clk), .i_page(adv[0]), .o_seen(seen[0]));
    lp_model lp1 (.i_clk_sys(clk), .i_page(adv[1]), .o_seen(seen[1]));
    initial forever #25 clk = ~clk;
    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            close_out();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    // Strap-derived reset word; fiber mode clears pause and 10BASE-T bits
    function automatic int dflt(input an_adv_pkg::strap_set_t s);
        int v;
        v = 32'h0000_0181;
        if (!s.fiber_mode && !s.manual_pause_select_latch)
        begin
            v += 32'h0000_0400;
            if (s.full_duplex_pause_latch)
            begin
                v += 32'h0000_0800;
            end
        end
        if (!s.fiber_mode && (s.autoneg || (!s.speed && s.duplex)))
        begin
            v += 32'h0000_0040;
        end
        if (!s.fiber_mode && (s.autoneg || !s.speed))
        begin
            v += 32'h0000_0020;
        end
        return v;
    endfunction : dflt
    // One APB transfer, held until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, ad, d, strb};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        rd = prdata;
        ev = err;
        req <= '0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_page(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t page got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_page
    task automatic chk_err(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t slverr got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_err
    task automatic close_out();
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    // Each pass: new straps, reset, check defaults, then write and read back
    initial
    begin
        for (int i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            straps <= seed[11:0];
            rst <= 1'b1;
            repeat (6) @(posedge clk);
            rst <= 1'b0;
            repeat (2) @(posedge clk);
            for (int p = 0; p < 2; p++)
            begin
                a = 12'(an_adv_pkg::ADV_ADDR + an_adv_pkg::PHY_STRIDE * p);
                model[p] = dflt(straps[p]);
                apb(1'b0, a, 32'h0);
                chk(rd, 32'(model[p]));
                chk_page(seen[p], 16'(model[p]));
                seed = lfsr(seed);
                apb(1'b1, a, {seed, seed & 16'hEFFF});
                model[p] = int'(seed & 16'hEFFF & an_adv_pkg::WRITE_MASK);
                apb(1'b0, a, 32'h0);
                chk(rd, 32'(model[p]));
            end
        end
        apb(1'b0, 12'h0FC, 32'h0);
        chk(rd, 32'h0000_0000);
        chk_err(ev, 1'b1);
        apb(1'b1, an_adv_pkg::STRAP_ADDR, 32'hFFFF);
        chk_err(ev, 1'b1);
        // Strap view: byte i holds PHY i straps
        apb(1'b0, an_adv_pkg::STRAP_ADDR, 32'h0);
        chk(rd, {16'h0000, 2'b00, straps[1], 2'b00, straps[0]});
        chk_err(ev, 1'b0);
        apb(1'b0, an_adv_pkg::ADV_ADDR, 32'h0);
        chk(rd, 32'(model[0]));
        // Low byte lane only on PHY 1: the upper byte must keep its value
        a = 12'(an_adv_pkg::ADV_ADDR + an_adv_pkg::PHY_STRIDE);
        seed = lfsr(seed);
        strb = 4'h1;
        apb(1'b1, a, {16'hFFFF, seed});
        strb = 4'hF;
        model[1] = (model[1] & 32'h0000_FF00) | int'(seed & 16'h00FF & an_adv_pkg::WRITE_MASK);
        apb(1'b0, a, 32'h0);
        chk(rd, 32'(model[1]));
        close_out();
    end
endmodule : an_adv_regs_tb
